// File: audio_cfg_pkg.sv
// Constants for the audio processing-path configuration register bank.
// Assumes a 125 MHz core clock and an 8-bit register port from the control front end.
package audio_cfg_pkg;

	// Register offsets on the control port
	localparam logic [7:0] OUTPUT_STAGE_CONFIG_ADDR = 8'h02;
	localparam logic [7:0] PROCESSING_PATH_CONFIG_ADDR = 8'h03;
	localparam logic [7:0] VOLUME_AND_MODULATION_CONFIG_ADDR = 8'h04;
	localparam logic [7:0] CORRECTION_COEF_HI_ADDR = 8'h27;
	localparam logic [7:0] CORRECTION_COEF_LO_ADDR = 8'h28;

	// Values after reset
	localparam logic [7:0] OUTPUT_STAGE_CONFIG_RESET = 8'h42;
	localparam logic [7:0] PROCESSING_PATH_CONFIG_RESET = 8'h40;
	localparam logic [7:0] VOLUME_AND_MODULATION_CONFIG_RESET = 8'hC2;
	localparam logic [7:0] CORRECTION_COEF_HI_RESET = 8'h00;
	localparam logic [7:0] CORRECTION_COEF_LO_RESET = 8'h00;
	// Fixed coefficient used when the variable one is not selected
	localparam logic [15:0] STANDARD_CORRECTION_COEF = 16'h0000;

	// Readable bits of the output stage and volume registers; the rest read as zero
	localparam logic [7:0] OUTPUT_STAGE_CONFIG_MASK = 8'h7F;
	localparam logic [7:0] VOLUME_AND_MODULATION_CONFIG_MASK = 8'hDB;

	// Output stage register fields
	localparam int OUTPUT_STAGE_MODE_LSB = 0;
	localparam int COMP_PULSE_SIZE_LSB = 2;
	localparam logic [1:0] OUTPUT_STAGE_MODE_VARIABLE = 2'h3;

	// Processing path register bits
	localparam int DC_FILTER_BYPASS_BIT = 0;
	localparam int DEEMPHASIS_ENABLE_BIT = 1;
	localparam int PROCESSING_BYPASS_BIT = 2;
	localparam int POSTSCALE_LINK_BIT = 3;
	localparam int COEFFICIENT_LINK_BIT = 4;
	localparam int LIMITER_COMPRESS_MODE_BIT = 5;
	localparam int ZERO_DETECT_MUTE_ENABLE_BIT = 6;
	localparam int SUB_MIX_ENABLE_BIT = 7;

	// Volume and modulation register bits
	localparam int VARIABLE_CORRECTION_SELECT_BIT = 0;
	localparam int POWER_CORRECTION_ENABLE_BIT = 1;
	localparam int AM_REDUCTION_ENABLE_BIT = 3;
	localparam int PWM_SPEED_SELECT_BIT = 4;
	localparam int ZERO_CROSS_VOLUME_ENABLE_BIT = 6;
	localparam int SOFT_VOLUME_ENABLE_BIT = 7;

	// Channel count and zero-run length
	localparam int NUM_CHANNELS = 3;
	localparam logic [11:0] ZERO_RUN_SAMPLES = 12'h800;

	// PWM frame rates and the derived frame lengths in core cycles
	localparam int CORE_CLK_HZ = 125000000;
	localparam int PWM_NORMAL_HZ = 384000;
	localparam int PWM_ODD_HZ = 341300;
	localparam logic [9:0] PWM_NORMAL_CYCLES = 10'(CORE_CLK_HZ / PWM_NORMAL_HZ);
	localparam logic [9:0] PWM_ODD_CYCLES = 10'(CORE_CLK_HZ / PWM_ODD_HZ);

endpackage

// File: comp_pulse_gen.sv
// Compensating pulse generator: one pulse per PWM frame, length in core cycles.
// Assumes i_start is a one-cycle pulse at each frame start.
`timescale 1ns/1ps
module comp_pulse_gen (
	input wire logic i_core_clk,
	input wire logic i_rst_n,
	input wire logic i_start,
	input wire logic i_enable,
	input wire logic [4:0] i_size,
	output logic o_pulse
);
	logic [4:0] cnt_ff; // Cycles left in the pulse
	logic [4:0] nxt_cnt;
	logic pulse_ff;

	// Load at frame start, then count down; a size of zero yields no pulse
	always_comb begin
		nxt_cnt = cnt_ff;
		if (i_start && i_enable) begin
			nxt_cnt = i_size;
		end else if (cnt_ff != 5'h00) begin
			nxt_cnt = cnt_ff - 5'h01;
		end
	end

	// Pulse is high exactly while the counter is nonzero
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cnt_ff <= 5'h00;
			pulse_ff <= 1'b0;
		end else begin
			cnt_ff <= nxt_cnt;
			pulse_ff <= (nxt_cnt != 5'h00);
		end
	end

	assign o_pulse = pulse_ff;
endmodule // comp_pulse_gen

// File: zero_detect_mute.sv
// Per-channel zero-run detector: mutes a channel after a long run of zero samples.
// Assumes samples arrive after channel mapping with a one-cycle valid per sample.
`timescale 1ns/1ps
module zero_detect_mute
	import audio_cfg_pkg::*;
(
	input wire logic i_core_clk,
	input wire logic i_rst_n,
	input wire logic i_enable,
	input wire logic [NUM_CHANNELS-1:0] i_sample_valid,
	input wire logic [NUM_CHANNELS-1:0] i_sample_zero,
	output logic [NUM_CHANNELS-1:0] o_mute
);
	logic [11:0] run_ff [NUM_CHANNELS]; // Zero samples seen in a row, saturating
	logic [NUM_CHANNELS-1:0] mute_ff;

	// Count by sample, not by time, so the limit holds for any sample rate
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			for (int ch = 0; ch < NUM_CHANNELS; ch++) begin
				run_ff[ch] <= 12'h000;
			end
			mute_ff <= '0;
		end else begin
			for (int ch = 0; ch < NUM_CHANNELS; ch++) begin
				if (i_sample_valid[ch]) begin
					if (!i_sample_zero[ch]) begin
						run_ff[ch] <= 12'h000; // Any nonzero sample restarts the run
					end else if (run_ff[ch] != ZERO_RUN_SAMPLES) begin
						run_ff[ch] <= run_ff[ch] + 12'h001;
					end
				end
				// Disabling the feature releases the mute at once
				mute_ff[ch] <= i_enable && (run_ff[ch] == ZERO_RUN_SAMPLES);
			end
		end
	end

	assign o_mute = mute_ff;
endmodule // zero_detect_mute

// File: audio_dsp_config_regs.sv
// Configuration register bank for the audio processing path and modulator.
// Assumes an 8-bit register port driven by the control front end, synchronous to the
// core clock, with one-cycle write and read strobes.
`timescale 1ns/1ps
module audio_dsp_config_regs
	import audio_cfg_pkg::*;
(
	input wire logic i_core_clk,
	input wire logic i_rst_n,
	// Register port from the control front end
	input wire logic [7:0] i_reg_addr,
	input wire logic [7:0] i_reg_wdata,
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	output logic [7:0] o_reg_rdata,
	output logic o_reg_rvalid,
	// Status from the datapath
	input wire logic [audio_cfg_pkg::NUM_CHANNELS-1:0] i_sample_valid,
	input wire logic [audio_cfg_pkg::NUM_CHANNELS-1:0] i_sample_zero,
	input wire logic [audio_cfg_pkg::NUM_CHANNELS-1:0] i_channel_volume_bypass,
	// Controls to the datapath
	output logic o_dc_filter_active,
	output logic o_deemphasis_active,
	output logic o_processing_bypass,
	output logic [5:0] o_postscale_src,
	output logic o_postscale_after_volume,
	output logic [5:0] o_coef_src,
	output logic o_limiter_compress_mode,
	output logic o_threshold_track_volume,
	output logic [audio_cfg_pkg::NUM_CHANNELS-1:0] o_zero_mute,
	output logic o_sub_mix_enable,
	output logic o_power_correction_enable,
	output logic [15:0] o_correction_coefficient,
	output logic o_am_reduction_enable,
	output logic o_pwm_speed_select,
	output logic o_pwm_frame_tick,
	output logic o_comp_pulse,
	output logic o_zero_cross_volume_enable,
	output logic [audio_cfg_pkg::NUM_CHANNELS-1:0] o_soft_volume_active
);
	import audio_cfg_pkg::*;

	// Stored register contents
	logic [7:0] output_stage_config_ff; // Mode and pulse size
	logic [7:0] processing_path_config_ff; // Filter, bypass, links, limiter, mutes
	logic [7:0] volume_and_modulation_config_ff; // Correction, modulation, volume update
	logic [7:0] correction_coef_hi_ff; // Upper byte of the variable coefficient
	logic [7:0] correction_coef_lo_ff; // Lower byte of the variable coefficient

	// Read port
	logic [7:0] rdata_ff;
	logic rvalid_ff;
	logic [7:0] nxt_rdata;

	// Decoded datapath controls, each held in a flop so outputs never glitch
	logic dc_filter_active_ff;
	logic deemphasis_active_ff;
	logic processing_bypass_ff;
	logic [5:0] postscale_src_ff;
	logic postscale_after_volume_ff;
	logic [5:0] coef_src_ff;
	logic limiter_compress_mode_ff;
	logic threshold_track_volume_ff;
	logic sub_mix_enable_ff;
	logic power_correction_enable_ff;
	logic [15:0] correction_coefficient_ff;
	logic am_reduction_enable_ff;
	logic pwm_speed_select_ff;
	logic zero_cross_volume_enable_ff;
	logic [NUM_CHANNELS-1:0] soft_volume_active_ff;

	// PWM frame timer
	logic [9:0] frame_cnt_ff; // Cycles into the current frame
	logic frame_tick_ff;
	logic [9:0] frame_len; // Length picked by the speed bit

	// Field views of the stored registers
	logic [1:0] output_stage_mode;
	logic [4:0] comp_pulse_size;
	logic zero_detect_mute_enable;

	// Source channel index for a linked or unlinked setting, two bits per channel
	function automatic logic [5:0] link_sources(input logic link);
		logic [5:0] src;
		src = 6'h00;
		for (int ch = 0; ch < NUM_CHANNELS; ch++) begin
			src[ch*2 +: 2] = link ? 2'h0 : 2'(ch);
		end
		return src;
	endfunction

	// Field views
	assign output_stage_mode = output_stage_config_ff[OUTPUT_STAGE_MODE_LSB +: 2];
	assign comp_pulse_size = output_stage_config_ff[COMP_PULSE_SIZE_LSB +: 5];
	assign zero_detect_mute_enable = processing_path_config_ff[ZERO_DETECT_MUTE_ENABLE_BIT];

	// Register writes; unmapped addresses are ignored
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			output_stage_config_ff <= OUTPUT_STAGE_CONFIG_RESET;
			processing_path_config_ff <= PROCESSING_PATH_CONFIG_RESET;
			volume_and_modulation_config_ff <= VOLUME_AND_MODULATION_CONFIG_RESET;
			correction_coef_hi_ff <= CORRECTION_COEF_HI_RESET;
			correction_coef_lo_ff <= CORRECTION_COEF_LO_RESET;
		end else if (i_reg_wr) begin
			unique case (i_reg_addr)
				OUTPUT_STAGE_CONFIG_ADDR: begin
					// Top bit is reserved and kept at zero
					output_stage_config_ff <= i_reg_wdata & OUTPUT_STAGE_CONFIG_MASK;
				end
				PROCESSING_PATH_CONFIG_ADDR: begin
					processing_path_config_ff <= i_reg_wdata;
				end
				VOLUME_AND_MODULATION_CONFIG_ADDR: begin
					// Reserved positions are dropped on write
					volume_and_modulation_config_ff <=
						i_reg_wdata & VOLUME_AND_MODULATION_CONFIG_MASK;
				end
				CORRECTION_COEF_HI_ADDR: begin
					correction_coef_hi_ff <= i_reg_wdata;
				end
				CORRECTION_COEF_LO_ADDR: begin
					correction_coef_lo_ff <= i_reg_wdata;
				end
				default: begin
					// Address outside this bank
				end
			endcase
		end
	end

	// Read mux; unmapped addresses read as zero
	always_comb begin
		unique case (i_reg_addr)
			OUTPUT_STAGE_CONFIG_ADDR: nxt_rdata = output_stage_config_ff;
			PROCESSING_PATH_CONFIG_ADDR: nxt_rdata = processing_path_config_ff;
			VOLUME_AND_MODULATION_CONFIG_ADDR: begin
				nxt_rdata = volume_and_modulation_config_ff & VOLUME_AND_MODULATION_CONFIG_MASK;
			end
			CORRECTION_COEF_HI_ADDR: nxt_rdata = correction_coef_hi_ff;
			CORRECTION_COEF_LO_ADDR: nxt_rdata = correction_coef_lo_ff;
			default: nxt_rdata = 8'h00;
		endcase
	end

	// Read data is captured one cycle after the strobe and held until the next read
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rdata_ff <= 8'h00;
			rvalid_ff <= 1'b0;
		end else begin
			rvalid_ff <= i_reg_rd;
			if (i_reg_rd) begin
				rdata_ff <= nxt_rdata;
			end
		end
	end

	// Filter, bypass and linking controls for the processing path
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			dc_filter_active_ff <= 1'b0;
			deemphasis_active_ff <= 1'b0;
			processing_bypass_ff <= 1'b0;
			postscale_src_ff <= 6'h00;
			postscale_after_volume_ff <= 1'b0;
			coef_src_ff <= 6'h00;
		end else begin
			// Filter stays in the path unless bypassed; DC can damage speakers
			dc_filter_active_ff <= !processing_path_config_ff[DC_FILTER_BYPASS_BIT];
			// De-emphasis lives inside the processing, so bypass defeats it
			deemphasis_active_ff <= processing_path_config_ff[DEEMPHASIS_ENABLE_BIT]
				&& !processing_path_config_ff[PROCESSING_BYPASS_BIT];
			processing_bypass_ff <= processing_path_config_ff[PROCESSING_BYPASS_BIT];
			postscale_src_ff <= link_sources(processing_path_config_ff[POSTSCALE_LINK_BIT]);
			// Post-scale placement is fixed: after volume, just ahead of the modulator
			postscale_after_volume_ff <= 1'b1;
			coef_src_ff <= link_sources(processing_path_config_ff[COEFFICIENT_LINK_BIT]);
		end
	end

	// Limiter and mixing controls
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			limiter_compress_mode_ff <= 1'b0;
			threshold_track_volume_ff <= 1'b0;
			sub_mix_enable_ff <= 1'b0;
		end else begin
			limiter_compress_mode_ff <= processing_path_config_ff[LIMITER_COMPRESS_MODE_BIT];
			// Thresholds follow volume only when compressing
			threshold_track_volume_ff <=
				processing_path_config_ff[LIMITER_COMPRESS_MODE_BIT];
			sub_mix_enable_ff <= processing_path_config_ff[SUB_MIX_ENABLE_BIT];
		end
	end

	// Modulator and correction controls
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			power_correction_enable_ff <= 1'b0;
			correction_coefficient_ff <= STANDARD_CORRECTION_COEF;
			am_reduction_enable_ff <= 1'b0;
			pwm_speed_select_ff <= 1'b0;
		end else begin
			power_correction_enable_ff <=
				volume_and_modulation_config_ff[POWER_CORRECTION_ENABLE_BIT];
			// Coefficient registers are only consulted when variable is selected
			if (volume_and_modulation_config_ff[VARIABLE_CORRECTION_SELECT_BIT]) begin
				correction_coefficient_ff <= {correction_coef_hi_ff, correction_coef_lo_ff};
			end else begin
				correction_coefficient_ff <= STANDARD_CORRECTION_COEF;
			end
			// Trades about 83 dB SNR for a quiet AM band
			am_reduction_enable_ff <= volume_and_modulation_config_ff[AM_REDUCTION_ENABLE_BIT];
			pwm_speed_select_ff <= volume_and_modulation_config_ff[PWM_SPEED_SELECT_BIT];
		end
	end

	// Volume update controls, soft ramp gated per channel by its volume bypass
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			zero_cross_volume_enable_ff <= 1'b0;
			soft_volume_active_ff <= '0;
		end else begin
			zero_cross_volume_enable_ff <=
				volume_and_modulation_config_ff[ZERO_CROSS_VOLUME_ENABLE_BIT];
			for (int ch = 0; ch < NUM_CHANNELS; ch++) begin
				soft_volume_active_ff[ch] <=
					volume_and_modulation_config_ff[SOFT_VOLUME_ENABLE_BIT]
					&& !i_channel_volume_bypass[ch];
			end
		end
	end

	// Frame length follows the speed bit; integer division, so rates are approximate
	assign frame_len = pwm_speed_select_ff ? PWM_ODD_CYCLES : PWM_NORMAL_CYCLES;

	// PWM frame timer; a speed change applies to the frame in progress, which ends at once if already past the new length
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			frame_cnt_ff <= 10'h000;
			frame_tick_ff <= 1'b0;
		end else begin
			if (frame_cnt_ff >= frame_len - 10'h001) begin
				frame_cnt_ff <= 10'h000;
				frame_tick_ff <= 1'b1;
			end else begin
				frame_cnt_ff <= frame_cnt_ff + 10'h001;
				frame_tick_ff <= 1'b0;
			end
		end
	end

	// Compensating pulse, once per frame, only in variable compensation mode
	comp_pulse_gen u_comp_pulse_gen (
		.i_core_clk(i_core_clk),
		.i_rst_n(i_rst_n),
		.i_start(frame_tick_ff),
		.i_enable(output_stage_mode == OUTPUT_STAGE_MODE_VARIABLE),
		.i_size(comp_pulse_size),
		.o_pulse(o_comp_pulse)
	);

	// Zero-run mute per mapped channel
	zero_detect_mute u_zero_detect_mute (
		.i_core_clk(i_core_clk),
		.i_rst_n(i_rst_n),
		.i_enable(zero_detect_mute_enable),
		.i_sample_valid(i_sample_valid),
		.i_sample_zero(i_sample_zero),
		.o_mute(o_zero_mute)
	);

	// Outputs straight from flops
	assign o_reg_rdata = rdata_ff;
	assign o_reg_rvalid = rvalid_ff;
	assign o_dc_filter_active = dc_filter_active_ff;
	assign o_deemphasis_active = deemphasis_active_ff;
	assign o_processing_bypass = processing_bypass_ff;
	assign o_postscale_src = postscale_src_ff;
	assign o_postscale_after_volume = postscale_after_volume_ff;
	assign o_coef_src = coef_src_ff;
	assign o_limiter_compress_mode = limiter_compress_mode_ff;
	assign o_threshold_track_volume = threshold_track_volume_ff;
	assign o_sub_mix_enable = sub_mix_enable_ff;
	assign o_power_correction_enable = power_correction_enable_ff;
	assign o_correction_coefficient = correction_coefficient_ff;
	assign o_am_reduction_enable = am_reduction_enable_ff;
	assign o_pwm_speed_select = pwm_speed_select_ff;
	assign o_pwm_frame_tick = frame_tick_ff;
	assign o_zero_cross_volume_enable = zero_cross_volume_enable_ff;
	assign o_soft_volume_active = soft_volume_active_ff;

endmodule // audio_dsp_config_regs

// File: audio_dsp_config_regs_asserts.sv
// Checker for the audio path configuration bank: port, controls, pulse.
// Assumes it is bound to the bank's top module and sees only its ports.
`timescale 1ns/1ps
module audio_dsp_config_regs_asserts
	import audio_cfg_pkg::*;
(
	input logic i_core_clk,
	input logic i_rst_n,
	input logic [7:0] i_reg_addr,
	input logic [7:0] i_reg_wdata,
	input logic i_reg_wr,
	input logic i_reg_rd,
	input logic [7:0] o_reg_rdata,
	input logic o_reg_rvalid,
	input logic [audio_cfg_pkg::NUM_CHANNELS-1:0] i_channel_volume_bypass,
	input logic o_dc_filter_active,
	input logic o_deemphasis_active,
	input logic o_processing_bypass,
	input logic [5:0] o_postscale_src,
	input logic [5:0] o_coef_src,
	input logic o_limiter_compress_mode,
	input logic o_threshold_track_volume,
	input logic [audio_cfg_pkg::NUM_CHANNELS-1:0] o_zero_mute,
	input logic o_sub_mix_enable,
	input logic [15:0] o_correction_coefficient,
	input logic o_pwm_frame_tick,
	input logic o_comp_pulse,
	input logic [audio_cfg_pkg::NUM_CHANNELS-1:0] o_soft_volume_active
);
	logic up_ff; // Set once decoded outputs carry register values
	logic [7:0] stage_ff; // Shadow of the output stage register
	logic [7:0] proc_ff; // Shadow of the processing path register
	logic [7:0] vm_ff; // Shadow of the volume and modulation register
	logic [15:0] coef_ff; // Shadow of the two coefficient bytes
	logic [5:0] plen_ff; // Length of the current pulse so far
	logic [4:0] sz_ff; // Size expected for this frame's pulse

	default clocking cb_core @(posedge i_core_clk); endclocking
	default disable iff (!i_rst_n);

	// Outputs lag reset release by one edge
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			up_ff <= 1'b0;
		end else begin
			up_ff <= 1'b1;
		end
	end

	// Register shadows, mapped addresses only
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			stage_ff <= OUTPUT_STAGE_CONFIG_RESET;
			proc_ff <= PROCESSING_PATH_CONFIG_RESET;
			vm_ff <= VOLUME_AND_MODULATION_CONFIG_RESET;
			coef_ff <= 16'h0000;
		end else if (i_reg_wr) begin
			case (i_reg_addr)
				OUTPUT_STAGE_CONFIG_ADDR: stage_ff <= i_reg_wdata;
				PROCESSING_PATH_CONFIG_ADDR: proc_ff <= i_reg_wdata;
				VOLUME_AND_MODULATION_CONFIG_ADDR: vm_ff <= i_reg_wdata;
				CORRECTION_COEF_HI_ADDR: coef_ff[15:8] <= i_reg_wdata;
				CORRECTION_COEF_LO_ADDR: coef_ff[7:0] <= i_reg_wdata;
				default: ;
			endcase
		end
	end

	// Pulse length so far, size latched at the tick
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			plen_ff <= 6'h00;
			sz_ff <= 5'h00;
		end else begin
			plen_ff <= o_comp_pulse ? plen_ff + 6'h01 : 6'h00;
			if (o_pwm_frame_tick) begin
				sz_ff <= (stage_ff[1:0] == OUTPUT_STAGE_MODE_VARIABLE) ? stage_ff[6:2] : 5'h00;
			end
		end
	end

	sequence s_go;
		o_pwm_frame_tick && stage_ff[1:0] == OUTPUT_STAGE_MODE_VARIABLE && stage_ff[6:2] != 5'h00;
	endsequence
	sequence s_off;
		o_pwm_frame_tick && stage_ff[1:0] != OUTPUT_STAGE_MODE_VARIABLE;
	endsequence

	AST_DC_FILTER: assert property (up_ff |-> o_dc_filter_active == !$past(proc_ff[0]))
		else $error("dc filter control wrong");
	AST_DEEMPH: assert property (
		up_ff |-> o_deemphasis_active == $past(proc_ff[1] & ~proc_ff[2]))
		else $error("deemphasis control wrong");
	AST_BYPASS: assert property (up_ff |-> o_processing_bypass == $past(proc_ff[2]))
		else $error("processing bypass wrong");
	AST_POST_LINK: assert property (
		up_ff |-> o_postscale_src == ($past(proc_ff[3]) ? 6'h00 : 6'h24))
		else $error("postscale source wrong");
	AST_COEF_LINK: assert property (
		up_ff |-> o_coef_src == ($past(proc_ff[4]) ? 6'h00 : 6'h24))
		else $error("coefficient source wrong");
	AST_LIMITER: assert property (
		up_ff |-> {o_limiter_compress_mode, o_threshold_track_volume} == {2{$past(proc_ff[5])}})
		else $error("limiter mode wrong");
	AST_ZMUTE_OFF: assert property (up_ff && !$past(proc_ff[6]) |-> o_zero_mute == '0)
		else $error("mute while disabled");
	AST_SUBMIX: assert property (up_ff |-> o_sub_mix_enable == $past(proc_ff[7]))
		else $error("sub mix control wrong");
	AST_COEF: assert property (
		up_ff |-> o_correction_coefficient ==
		($past(vm_ff[0]) ? $past(coef_ff) : STANDARD_CORRECTION_COEF))
		else $error("coefficient wrong");
	AST_SOFTVOL: assert property (
		up_ff |-> o_soft_volume_active ==
		({NUM_CHANNELS{$past(vm_ff[7])}} & ~$past(i_channel_volume_bypass)))
		else $error("soft volume gating wrong");
	AST_RD_VM: assert property (
		i_reg_rd && i_reg_addr == VOLUME_AND_MODULATION_CONFIG_ADDR |=> o_reg_rvalid
		&& o_reg_rdata == ($past(vm_ff) & VOLUME_AND_MODULATION_CONFIG_MASK))
		else $error("volume readback wrong");
	AST_PULSE_START: assert property (s_go |=> o_comp_pulse)
		else $error("pulse missing after tick");
	AST_NO_PULSE: assert property (s_off |=> !o_comp_pulse)
		else $error("pulse outside variable mode");
	AST_PULSE_LEN: assert property ($fell(o_comp_pulse) |-> plen_ff == {1'b0, sz_ff})
		else $error("pulse length wrong");
endmodule // audio_dsp_config_regs_asserts

bind audio_dsp_config_regs audio_dsp_config_regs_asserts i_chk (.*);

// File: tb_audio_dsp_config_regs.sv
// Testbench for the audio path configuration bank: register calls with expected values.
// Assumes the bank's one-cycle strobe port; inputs change at the falling clock edge.
`timescale 1ns/1ps
module tb_audio_dsp_config_regs;
	import audio_cfg_pkg::*;
	logic i_core_clk = 1'b0;
	logic i_rst_n = 1'b0;
	logic [7:0] i_reg_addr = 8'h00;
	logic [7:0] i_reg_wdata = 8'h00;
	logic i_reg_wr = 1'b0;
	logic i_reg_rd = 1'b0;
	logic [NUM_CHANNELS-1:0] i_sample_valid = '0;
	logic [NUM_CHANNELS-1:0] i_sample_zero = '0;
	logic [NUM_CHANNELS-1:0] i_channel_volume_bypass = '0;
	logic [7:0] o_reg_rdata;
	logic o_reg_rvalid, o_dc_filter_active, o_deemphasis_active, o_processing_bypass;
	logic [5:0] o_postscale_src, o_coef_src;
	logic o_postscale_after_volume, o_limiter_compress_mode, o_threshold_track_volume;
	logic [NUM_CHANNELS-1:0] o_zero_mute, o_soft_volume_active;
	logic o_sub_mix_enable, o_power_correction_enable, o_am_reduction_enable;
	logic [15:0] o_correction_coefficient;
	logic o_pwm_speed_select, o_pwm_frame_tick, o_comp_pulse, o_zero_cross_volume_enable;
	int error_cnt = 0;
	int num_checks = 0;
	logic [7:0] pv [9] = '{8'h01, 8'h02, 8'h04, 8'h06, 8'h08, 8'h10, 8'h20, 8'h80, 8'h00};
	logic [7:0] vv [7] = '{8'h01, 8'h02, 8'h08, 8'h10, 8'h40, 8'h80, 8'h00};

	// Free-running core clock, 8 ns period
	always #4 i_core_clk = ~i_core_clk;

	audio_dsp_config_regs i_dut (.i_core_clk, .i_rst_n, .i_reg_addr, .i_reg_wdata, .i_reg_wr,
		.i_reg_rd, .o_reg_rdata, .o_reg_rvalid, .i_sample_valid, .i_sample_zero,
		.i_channel_volume_bypass, .o_dc_filter_active, .o_deemphasis_active,
		.o_processing_bypass, .o_postscale_src, .o_postscale_after_volume, .o_coef_src,
		.o_limiter_compress_mode, .o_threshold_track_volume, .o_zero_mute, .o_sub_mix_enable,
		.o_power_correction_enable, .o_correction_coefficient, .o_am_reduction_enable,
		.o_pwm_speed_select, .o_pwm_frame_tick, .o_comp_pulse, .o_zero_cross_volume_enable,
		.o_soft_volume_active);

	// Verdict and end of run
	task automatic conclude();
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// Compare of a multi-bit result
	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
		num_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	// Compare of a single control bit
	task automatic chk1(input logic got, input logic exp, input string what);
		chk(16'(got), 16'(exp), what);
	endtask

	// One write strobe, held across one rising edge
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge i_core_clk);
		i_reg_addr = a;
		i_reg_wdata = d;
		i_reg_wr = 1'b1;
		@(negedge i_core_clk);
		i_reg_wr = 1'b0;
	endtask

	// One read strobe; answer stands one cycle
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(negedge i_core_clk);
		i_reg_addr = a;
		i_reg_rd = 1'b1;
		@(negedge i_core_clk);
		i_reg_rd = 1'b0;
		chk1(o_reg_rvalid, 1'b1, "rvalid");
		chk(16'(o_reg_rdata), 16'(exp), "rdata");
	endtask

	// Valid for n edges on the masked channels
	task automatic samples(input logic [2:0] m, input logic z, input int n);
		@(negedge i_core_clk);
		i_sample_valid = m;
		i_sample_zero = {3{z}};
		repeat (n) @(negedge i_core_clk);
		i_sample_valid = '0;
	endtask

	// Next frame tick, bounded by one long frame
	task automatic wait_tick();
		int n;
		n = 0;
		@(negedge i_core_clk);
		while (o_pwm_frame_tick !== 1'b1 && n < 400) begin
			@(negedge i_core_clk);
			n++;
		end
		chk1(o_pwm_frame_tick, 1'b1, "tick");
	endtask

	// Spacing of two ticks in core cycles
	task automatic frame_len(input int exp);
		int n;
		n = 0;
		wait_tick();
		do begin
			@(negedge i_core_clk);
			n++;
		end while (o_pwm_frame_tick !== 1'b1 && n < 400);
		chk(16'(n), 16'(exp), "frame length");
	endtask

	// Sets the stage register mid-frame, counts next frame's pulse
	task automatic pulse(input logic [7:0] c, input int exp);
		int n;
		n = 0;
		wait_tick();
		wr(OUTPUT_STAGE_CONFIG_ADDR, c);
		wait_tick();
		repeat (40) begin
			@(negedge i_core_clk);
			if (o_comp_pulse === 1'b1) n++;
		end
		chk(16'(n), 16'(exp), "pulse length");
	endtask

	// Hang guard, far beyond the expected run
	initial begin
		#300000;
		error_cnt++;
		$display("[ERR] %0t watchdog expired", $time);
		conclude();
	end

	// Main sequence
	initial begin
		repeat (3) @(negedge i_core_clk);
		i_rst_n = 1'b1;
		repeat (2) @(negedge i_core_clk);
		chk1(o_dc_filter_active, 1'b1, "reset dc");
		chk1(o_power_correction_enable, 1'b1, "reset pc");
		chk1(o_zero_cross_volume_enable, 1'b1, "reset zc");
		chk(16'(o_soft_volume_active), 16'h0007, "reset soft");
		rd(OUTPUT_STAGE_CONFIG_ADDR, 8'h42);
		rd(PROCESSING_PATH_CONFIG_ADDR, 8'h40);
		rd(VOLUME_AND_MODULATION_CONFIG_ADDR, 8'hC2);
		rd(CORRECTION_COEF_HI_ADDR, 8'h00);
		rd(CORRECTION_COEF_LO_ADDR, 8'h00);
		wr(8'h10, 8'h55);
		rd(8'h10, 8'h00);
		wr(VOLUME_AND_MODULATION_CONFIG_ADDR, 8'hFF);
		rd(VOLUME_AND_MODULATION_CONFIG_ADDR, 8'hDB);
		// Each processing bit alone except zero-detect mute (bit 6), plus de-emphasis under bypass
		foreach (pv[i]) begin
			wr(PROCESSING_PATH_CONFIG_ADDR, pv[i]);
			@(negedge i_core_clk);
			chk1(o_dc_filter_active, ~pv[i][0], "dc");
			chk1(o_deemphasis_active, pv[i][1] & ~pv[i][2], "deemph");
			chk1(o_processing_bypass, pv[i][2], "bypass");
			chk(16'(o_postscale_src), pv[i][3] ? 16'h0000 : 16'h0024, "post link");
			chk1(o_postscale_after_volume, 1'b1, "post order");
			chk(16'(o_coef_src), pv[i][4] ? 16'h0000 : 16'h0024, "coef link");
			chk1(o_limiter_compress_mode, pv[i][5], "limiter");
			chk1(o_threshold_track_volume, pv[i][5], "track");
			chk1(o_sub_mix_enable, pv[i][7], "submix");
			rd(PROCESSING_PATH_CONFIG_ADDR, pv[i]);
		end
		wr(CORRECTION_COEF_HI_ADDR, 8'h12);
		wr(CORRECTION_COEF_LO_ADDR, 8'h34);
		// Each modulation bit alone
		foreach (vv[i]) begin
			wr(VOLUME_AND_MODULATION_CONFIG_ADDR, vv[i]);
			@(negedge i_core_clk);
			chk(o_correction_coefficient, vv[i][0] ? 16'h1234 : 16'h0000, "coef");
			chk1(o_power_correction_enable, vv[i][1], "pc");
			chk1(o_am_reduction_enable, vv[i][3], "am");
			chk1(o_pwm_speed_select, vv[i][4], "speed");
			chk1(o_zero_cross_volume_enable, vv[i][6], "zc");
			chk(16'(o_soft_volume_active), 16'({3{vv[i][7]}}), "soft");
		end
		wr(VOLUME_AND_MODULATION_CONFIG_ADDR, 8'h80);
		i_channel_volume_bypass = 3'b101;
		repeat (2) @(negedge i_core_clk);
		chk(16'(o_soft_volume_active), 16'h0002, "soft bypass");
		// Zero run one short, then complete, then broken, then disabled
		wr(PROCESSING_PATH_CONFIG_ADDR, 8'h40);
		samples(3'b001, 1'b1, 2047);
		repeat (3) @(negedge i_core_clk);
		chk(16'(o_zero_mute), 16'h0000, "mute early");
		samples(3'b001, 1'b1, 1);
		repeat (2) @(negedge i_core_clk);
		chk(16'(o_zero_mute), 16'h0001, "mute");
		samples(3'b001, 1'b0, 1);
		repeat (2) @(negedge i_core_clk);
		chk(16'(o_zero_mute), 16'h0000, "unmute");
		samples(3'b010, 1'b1, 2048);
		repeat (2) @(negedge i_core_clk);
		chk(16'(o_zero_mute), 16'h0002, "mute ch1");
		wr(PROCESSING_PATH_CONFIG_ADDR, 8'h00);
		@(negedge i_core_clk);
		chk(16'(o_zero_mute), 16'h0000, "mute off");
		// Frame rates, then compensating pulse sizes and modes
		frame_len(PWM_NORMAL_CYCLES);
		wr(VOLUME_AND_MODULATION_CONFIG_ADDR, 8'h10);
		wait_tick();
		frame_len(PWM_ODD_CYCLES);
		pulse(8'h0F, 3);
		pulse(8'h7F, 31);
		pulse(8'h07, 1);
		pulse(8'h03, 0);
		pulse(8'h0E, 0);
		pulse(8'h7D, 0);
		conclude();
	end
endmodule // tb_audio_dsp_config_regs
